//--- shared/tsd_pkg.sv
package tsd_pkg;
    // Register offsets on the register interface.
    localparam logic [8:0] gain_trim_off = 9'h07a;
    localparam logic [8:0] bandgap_trim_off = 9'h07c;
    localparam logic [8:0] term_trim_a_off = 9'h07e;
    localparam logic [8:0] term_trim_b_off = 9'h07f;
    localparam logic [8:0] term_trim_c_off = 9'h080;
    localparam logic [8:0] term_trim_d_off = 9'h081;
    localparam logic [8:0] swap_overlap_off = 9'h09a;
    // Field positions and widths.
    localparam int bandgap_field_msb = 3;
    localparam int overlap_field_msb = 4;
    // Reset values.
    localparam logic [7:0] swap_overlap_reset = 8'h08;
    localparam logic [7:0] trim_fixed_reset = 8'h00;
    // Fixed part of the overlap window, in converter clock cycles.
    localparam logic [6:0] overlap_base_cycles = 7'h04;
    // Number of termination trim channels.
    localparam int term_chan_count = 4;
    // Fuse loader states.
    typedef enum logic [1:0] {
        tsd_fuse_idle_e = 2'b00,
        tsd_fuse_load_e = 2'b01,
        tsd_fuse_done_e = 2'b10
    } tsd_fuse_state_t;
endpackage

//--- core/tsd_overlap_calc.sv
`timescale 1ns/10ps
// Turns the programmed overlap delay into the swap overlap length in converter cycles.
module tsd_overlap_calc (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [4:0] delay_i,
    output logic [6:0] cycles_o
);
    // Registered so the analog side sees a clean, glitch-free count.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            // Matches the reset delay so the sequencer never sees a stale length.
            cycles_o <= tsd_pkg::overlap_base_cycles + {tsd_pkg::swap_overlap_reset[5:0], 1'b0};
        end
        else
        begin
            // Base four cycles plus two per step of delay.
            cycles_o <= tsd_pkg::overlap_base_cycles + {1'b0, delay_i, 1'b0};
        end
    end
endmodule

//--- core/tsd_trim_regs.sv
`timescale 1ns/10ps
module tsd_trim_regs (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [8:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic fuse_valid_i,
    input wire logic [7:0] fuse_gain_i,
    input wire logic [7:0] fuse_bandgap_i,
    input wire logic [31:0] fuse_term_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic fuse_done_o,
    output logic [7:0] gain_trim_o,
    output logic [3:0] bandgap_trim_o,
    output logic [31:0] term_trim_o,
    output logic [4:0] swap_overlap_delay_o,
    output logic [6:0] overlap_cycles_o
);
    // Stored register images, full eight bits so reserved bits read back.
    logic [7:0] gain_trim_value;
    logic [7:0] bandgap_trim_value;
    logic [7:0] term_trim [tsd_pkg::term_chan_count];
    logic [7:0] swap_overlap_delay;
    // Fuse loader state.
    tsd_pkg::tsd_fuse_state_t fuse_state;
    tsd_pkg::tsd_fuse_state_t next_fuse_state;
    logic fuse_load;
    // Read data mux result.
    logic [7:0] next_rdata;
    // Decoded termination channel select, shared by the write enables and the read mux.
    logic [2:0] term_sel;

    // Decodes a termination channel offset into its index; hit flags a match.
    function automatic logic [2:0] term_decode(input logic [8:0] addr);
        logic [2:0] r;
        r = 3'b000;
        case (addr)
            tsd_pkg::term_trim_a_off: r = 3'b100;
            tsd_pkg::term_trim_b_off: r = 3'b101;
            tsd_pkg::term_trim_c_off: r = 3'b110;
            tsd_pkg::term_trim_d_off: r = 3'b111;
            default: r = 3'b000;
        endcase
        // Every other offset decodes to zero, so bit 2 doubles as the hit flag.
        return r;
    endfunction

    // Decoded once here; a select on a function result is not portable.
    assign term_sel = term_decode(reg_addr_i);

    // Fuse data is only trusted once fuse_valid_i is seen after reset release;
    // the async reset itself can only load constants.
    always_comb
    begin
        next_fuse_state = fuse_state;
        case (fuse_state)
            tsd_pkg::tsd_fuse_idle_e: if (fuse_valid_i) next_fuse_state = tsd_pkg::tsd_fuse_load_e;
            tsd_pkg::tsd_fuse_load_e: next_fuse_state = tsd_pkg::tsd_fuse_done_e;
            tsd_pkg::tsd_fuse_done_e: next_fuse_state = tsd_pkg::tsd_fuse_done_e;
            default: next_fuse_state = tsd_pkg::tsd_fuse_idle_e;
        endcase
    end
    assign fuse_load = (fuse_state == tsd_pkg::tsd_fuse_load_e);

    // Loader state register.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            fuse_state <= tsd_pkg::tsd_fuse_idle_e;
            fuse_done_o <= 1'b0;
        end
        else
        begin
            fuse_state <= next_fuse_state;
            fuse_done_o <= (next_fuse_state == tsd_pkg::tsd_fuse_done_e);
        end
    end

    // Gain trim: one value for all cores, loaded from fuses then writable.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            gain_trim_value <= tsd_pkg::trim_fixed_reset;
        end
        else if (fuse_load)
        begin
            gain_trim_value <= fuse_gain_i;
        end
        else if (reg_wr_i && reg_addr_i == tsd_pkg::gain_trim_off)
        begin
            gain_trim_value <= reg_wdata_i;
        end
    end

    // Band-gap trim; reserved upper nibble is stored so it reads back as written.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            bandgap_trim_value <= tsd_pkg::trim_fixed_reset;
        end
        else if (fuse_load)
        begin
            bandgap_trim_value <= {4'h0, fuse_bandgap_i[tsd_pkg::bandgap_field_msb:0]};
        end
        else if (reg_wr_i && reg_addr_i == tsd_pkg::bandgap_trim_off)
        begin
            bandgap_trim_value <= reg_wdata_i;
        end
    end

    // One termination trim per input channel, each at consecutive offsets.
    genvar ch;
    generate
        for (ch = 0; ch < tsd_pkg::term_chan_count; ch++)
        begin : g_term
            // Each channel owns its flop, so no two processes share one array variable.
            logic [7:0] trim_q;
            always_ff @(posedge clk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                begin
                    trim_q <= tsd_pkg::trim_fixed_reset;
                end
                else if (fuse_load)
                begin
                    trim_q <= fuse_term_i[ch*8 +: 8];
                end
                else if (reg_wr_i && term_sel == {1'b1, 2'(ch)})
                begin
                    trim_q <= reg_wdata_i;
                end
            end
            // The read mux indexes the array by channel.
            assign term_trim[ch] = trim_q;
            // Trim outputs come straight from the stored registers.
            assign term_trim_o[ch*8 +: 8] = trim_q;
        end
    endgenerate

    // Overlap delay has a fixed reset and no fuse source. Calibration gating
    // is the software's job, so writes are taken at any time.
    // A write made while calibration runs would still land; keeping it out is up to software.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            swap_overlap_delay <= tsd_pkg::swap_overlap_reset;
        end
        else if (reg_wr_i && reg_addr_i == tsd_pkg::swap_overlap_off)
        begin
            swap_overlap_delay <= reg_wdata_i;
        end
    end

    // Read mux; unmapped offsets read as zero.
    always_comb
    begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            tsd_pkg::gain_trim_off: next_rdata = gain_trim_value;
            tsd_pkg::bandgap_trim_off: next_rdata = bandgap_trim_value;
            tsd_pkg::swap_overlap_off: next_rdata = swap_overlap_delay;
            default:
            begin
                // Only a termination offset sets the hit flag; all else reads zero.
                if (term_sel[2])
                begin
                    next_rdata = term_trim[term_sel[1:0]];
                end
            end
        endcase
    end

    // Read data is registered; one-cycle valid after the read strobe.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
            begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    // Analog-facing trim values; only the defined fields leave the bank.
    assign gain_trim_o = gain_trim_value;
    assign bandgap_trim_o = bandgap_trim_value[tsd_pkg::bandgap_field_msb:0];
    assign swap_overlap_delay_o = swap_overlap_delay[tsd_pkg::overlap_field_msb:0];

    // Overlap length for the swap sequencer.
    tsd_overlap_calc u_overlap (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .delay_i(swap_overlap_delay[tsd_pkg::overlap_field_msb:0]),
        .cycles_o(overlap_cycles_o)
    );
endmodule

//--- bench/tsd_trim_checker.sv
`timescale 1ns/10ps
// Watches the trim bank ports. Trim writes are judged only after the fuse load, since a load wins; delay writes at any time.
module tsd_trim_checker (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [8:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] fuse_gain_i,
    input wire logic reg_rvalid_o,
    input wire logic fuse_done_o,
    input wire logic [7:0] gain_trim_o,
    input wire logic [3:0] bandgap_trim_o,
    input wire logic [31:0] term_trim_o,
    input wire logic [4:0] swap_overlap_delay_o,
    input wire logic [6:0] overlap_cycles_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered next cycle");
    chk_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("read valid without a read");
    chk_overlap_calc: assert property (overlap_cycles_o == 7'(4 + 2 * $past(swap_overlap_delay_o)))
        else $error("overlap length wrong");
    chk_gain_write: assert property (fuse_done_o && reg_wr_i && reg_addr_i == 9'h07a
        |=> gain_trim_o == $past(reg_wdata_i)) else $error("gain trim not written");
    chk_bandgap_write: assert property (fuse_done_o && reg_wr_i && reg_addr_i == 9'h07c
        |=> bandgap_trim_o == $past(reg_wdata_i[3:0])) else $error("band-gap not written");
    chk_term_write: assert property (fuse_done_o && reg_wr_i && reg_addr_i == 9'h081
        |=> term_trim_o[31:24] == $past(reg_wdata_i)) else $error("channel d not written");
    chk_delay_write: assert property (reg_wr_i && reg_addr_i == 9'h09a
        |=> swap_overlap_delay_o == $past(reg_wdata_i[4:0])) else $error("delay not written");
    chk_fuse_load: assert property ($rose(fuse_done_o) |-> gain_trim_o == $past(fuse_gain_i))
        else $error("gain trim not fuse loaded");
    cover property (reg_rvalid_o);
    cover property ($rose(fuse_done_o));
    cover property (reg_wr_i && reg_addr_i == 9'h09a);
endmodule

//--- bench/tb_tsd_trim_regs.sv
`timescale 1ns/10ps
// Walks the bank: reset values, fuse load, a table of write and read rows, delay bounds.
module tb_tsd_trim_regs;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [8:0] reg_addr_i = 9'h000;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_rd_i = 1'b0;
    logic fuse_valid_i = 1'b0;
    logic [7:0] fuse_gain_i = 8'h5c;
    logic [7:0] fuse_bandgap_i = 8'ha5;
    logic [31:0] fuse_term_i = 32'h44332211;
    logic [7:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic fuse_done_o;
    logic [7:0] gain_trim_o;
    logic [3:0] bandgap_trim_o;
    logic [31:0] term_trim_o;
    logic [4:0] swap_overlap_delay_o;
    logic [6:0] overlap_cycles_o;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    // Rows of address, written data, expected readback; reserved bits are written as zero.
    // The gain row writes a trim only; full-scale range is never set through it.
    logic [24:0] rows [8] = '{{9'h07a, 8'h3c, 8'h3c}, {9'h07c, 8'h09, 8'h09},
        {9'h07e, 8'h81, 8'h81}, {9'h07f, 8'h7e, 8'h7e}, {9'h080, 8'hc3, 8'hc3},
        {9'h081, 8'h18, 8'h18}, {9'h09a, 8'h1f, 8'h1f}, {9'h07b, 8'h55, 8'h00}};
    tsd_trim_regs dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .fuse_valid_i(fuse_valid_i), .fuse_gain_i(fuse_gain_i), .fuse_bandgap_i(fuse_bandgap_i),
        .fuse_term_i(fuse_term_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .fuse_done_o(fuse_done_o), .gain_trim_o(gain_trim_o), .bandgap_trim_o(bandgap_trim_o),
        .term_trim_o(term_trim_o), .swap_overlap_delay_o(swap_overlap_delay_o),
        .overlap_cycles_o(overlap_cycles_o));
    // The clock toggles every half period of 12.5 ns.
    always #12.5 clk_i = ~clk_i;
    // Counts and reports one mismatch.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One write: the strobe is held for one edge only.
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // One read: the answer is looked at just after the edge that takes the strobe.
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid_o});
        chk("rdata", exp, reg_rdata_o);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // A hang is cut short well past the expected run of under a hundred cycles.
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(9'h09a, 8'h08);
        chk("overlap", 8'd20, {1'b0, overlap_cycles_o});
        @(posedge clk_i);
        fuse_valid_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("fuse_done", 8'h01, {7'h00, fuse_done_o});
        rd(9'h07a, 8'h5c);
        rd(9'h07c, 8'h05);
        rd(9'h081, 8'h44);
        chk("term_b", 8'h22, term_trim_o[15:8]);
        foreach (rows[i])
        begin
            wr(rows[i][24:16], rows[i][15:8]);
            rd(rows[i][24:16], rows[i][7:0]);
        end
        chk("overlap", 8'd66, {1'b0, overlap_cycles_o});
        wr(9'h09a, 8'h00);
        @(posedge clk_i);
        #1;
        chk("overlap", 8'd4, {1'b0, overlap_cycles_o});
        // Slow converter clocks may use seven for a shorter overlap window.
        wr(9'h09a, 8'h07);
        @(posedge clk_i);
        #1;
        chk("overlap", 8'd18, {1'b0, overlap_cycles_o});
        // A second reset mid-run drops every write; the still-valid fuses load again.
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("gain_rst", 8'h00, gain_trim_o);
        chk("delay_rst", 8'h08, {3'h0, swap_overlap_delay_o});
        chk("overlap_rst", 8'd20, {1'b0, overlap_cycles_o});
        chk("done_rst", 8'h00, {7'h00, fuse_done_o});
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("fuse_done", 8'h01, {7'h00, fuse_done_o});
        rd(9'h07a, 8'h5c);
        rd(9'h07e, 8'h11);
        rd(9'h09a, 8'h08);
        print_verdict();
    end
endmodule
bind tsd_trim_regs tsd_trim_checker chk_u (.*);
